// File: hw/cop_port_pkg.sv
// cop_port_pkg: constants and types shared by the coprocessor-side handshake unit
// assumes the core-side port uses the two-bit handshake encoding held here
package cop_port_pkg;

  // two-bit handshake states; merge of several units is AND on bit 1, OR on bit 0
  localparam logic [1:0] HS_ABSENT = 2'h2;
  localparam logic [1:0] HS_WAIT = 2'h0;
  localparam logic [1:0] HS_GO = 2'h1;
  localparam logic [1:0] HS_LAST = 2'h3;

  // instruction field positions
  localparam int CLASS_MSB = 27;
  localparam int CLASS_LSB = 24;
  localparam logic [3:0] CLASS_COP = 4'hE;
  localparam int CPNUM_MSB = 11;
  localparam int CPNUM_LSB = 8;
  localparam int XFER_BIT = 4;
  localparam int LOAD_BIT = 20;
  localparam int PRIV_BIT = 23;
  localparam int LONG_BIT = 22;
  localparam int CRN_LSB = 16;
  localparam int CRD_LSB = 12;
  localparam int CRM_LSB = 0;

  // sizes and defaults
  localparam int DATA_W = 32;
  localparam int REG_AW = 4;
  localparam int REG_DEPTH = 16;
  localparam int CNT_W = 8;
  localparam logic [3:0] COP_NUMBER_DEFAULT = 4'h5;
  localparam int BUSY_CYCLES_DEFAULT = 2;
  localparam logic [31:0] DATA_IDLE = 32'h0000_0000;

  typedef enum logic [1:0] {OP_NONE, OP_DATA, OP_TO_COP, OP_TO_CORE} op_kind_type;

  typedef struct packed {
    op_kind_type kind;
    logic priv;
    logic long_op;
    logic [REG_AW-1:0] crn;
    logic [REG_AW-1:0] crd;
    logic [REG_AW-1:0] crm;
  } instr_fields_type;

  typedef enum logic [1:0] {EX_IDLE, EX_FIRST, EX_BUSY} ex_state_type;

endpackage

// File: hw/cop_reg_file.sv
// cop_reg_file: coprocessor register bank, one write port, registered read ports
// assumes one clock; a write and a read of the same entry on one edge returns the new word
`timescale 1ns/100ps
`default_nettype none
module cop_reg_file #(
  parameter int DW = 32,
  parameter int AW = 4,
  parameter int DEPTH = 16,
  parameter int NRD = 2
) (
  // clock
  input wire logic i_mclk,
  // write port
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [DW-1:0] i_wdata,
  // read ports
  input wire logic [NRD-1:0][AW-1:0] i_raddr,
  output logic [NRD-1:0][DW-1:0] o_rdata
);

  logic [DW-1:0] mem [DEPTH];

  always_ff @(posedge i_mclk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  // registered reads with write bypass
  for (genvar p = 0; p < NRD; p++) begin : g_rd
    always_ff @(posedge i_mclk) begin
      if (i_we && i_waddr == i_raddr[p]) begin
        o_rdata[p] <= i_wdata;
      end else begin
        o_rdata[p] <= mem[i_raddr[p]];
      end
    end
  end

endmodule
`default_nettype wire

// File: hw/cop_handshake_unit.sv
// cop_handshake_unit: coprocessor end of the core's coprocessor handshake port
// assumes all core signals are on i_mclk, qualified by i_pipe_clock_enable
//
// Functional notes
// - advance strobe low: fetched word enters decode, decode handshake answers it
// - LAST on the active handshake bus commits the instruction for both sides
// - coprocessor supplies word on incoming bus for core's memory-stage sample
// - interlocked instruction stays in decode until the advance strobe moves it
// - immediately executable data op answers LAST on decode handshake
// - busy data op answers WAIT in decode, then LAST on execute handshake
// - late cancel after first execute: terminate with no state change
// - coprocessor tracks privilege mode, which may change during decode
// - to stall, WAIT on decode handshake then WAIT on execute as needed
// - each busy cycle: continue while condition pass high, abandon when low
// - several units merge handshakes: AND bit 1, OR bit 0
// - coprocessor pipeline moves only on enable high and advance strobe low
`timescale 1ns/100ps
`default_nettype none
module cop_handshake_unit #(
  parameter logic [3:0] CP_NUM = cop_port_pkg::COP_NUMBER_DEFAULT,
  parameter int BUSY_CYCLES = cop_port_pkg::BUSY_CYCLES_DEFAULT
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // pipeline follower
  input wire logic i_pipe_clock_enable,
  input wire logic i_pipe_advance_n,
  input wire logic [31:0] i_fetched_instr_bus,
  input wire logic i_user_mode_n,
  // execute control from core
  input wire logic i_cond_pass,
  input wire logic i_late_cancel,
  // data from core
  input wire logic [31:0] i_core_to_cop_data,
  // handshake and data to core
  output logic [1:0] o_decode_handshake,
  output logic [1:0] o_execute_handshake,
  output logic [31:0] o_cop_to_core_data
);

  localparam logic [cop_port_pkg::CNT_W-1:0] BUSY_LOAD =
    cop_port_pkg::CNT_W'(BUSY_CYCLES);

  cop_port_pkg::instr_fields_type dec_q;
  cop_port_pkg::instr_fields_type dec_next;
  cop_port_pkg::instr_fields_type ex_q;
  cop_port_pkg::ex_state_type state_q;
  logic [1:0] ex_resp_q;
  logic [cop_port_pkg::CNT_W-1:0] cnt_q;
  logic wb_pending_q;
  cop_port_pkg::op_kind_type wb_kind_q;
  logic [cop_port_pkg::REG_AW-1:0] wb_reg_q;
  logic [31:0] wb_sum_q;
  logic adv;
  logic commit;
  logic abandon;
  logic reg_we;
  logic [31:0] reg_wdata;
  logic [1:0][cop_port_pkg::REG_AW-1:0] raddr;
  logic [1:0][31:0] rdata;

  // split an instruction word into our fields
  function automatic cop_port_pkg::instr_fields_type decode_fields(input logic [31:0] w);
    cop_port_pkg::instr_fields_type f;
    f = '0;
    f.priv = w[cop_port_pkg::PRIV_BIT];
    f.long_op = ~w[cop_port_pkg::XFER_BIT] & w[cop_port_pkg::LONG_BIT];
    f.crn = w[cop_port_pkg::CRN_LSB +: cop_port_pkg::REG_AW];
    f.crd = w[cop_port_pkg::CRD_LSB +: cop_port_pkg::REG_AW];
    f.crm = w[cop_port_pkg::CRM_LSB +: cop_port_pkg::REG_AW];
    if (w[cop_port_pkg::CLASS_MSB:cop_port_pkg::CLASS_LSB] != cop_port_pkg::CLASS_COP ||
        w[cop_port_pkg::CPNUM_MSB:cop_port_pkg::CPNUM_LSB] != CP_NUM) begin
      f.kind = cop_port_pkg::OP_NONE;
    end else if (!w[cop_port_pkg::XFER_BIT]) begin
      f.kind = cop_port_pkg::OP_DATA;
    end else if (w[cop_port_pkg::LOAD_BIT]) begin
      f.kind = cop_port_pkg::OP_TO_CORE;
    end else begin
      f.kind = cop_port_pkg::OP_TO_COP;
    end
    return f;
  endfunction

  // decode-stage answer for one instruction in the current mode
  function automatic logic [1:0] respond(input cop_port_pkg::instr_fields_type f,
                                         input logic user);
    logic [1:0] r;
    r = cop_port_pkg::HS_LAST;
    if (f.kind == cop_port_pkg::OP_NONE || (f.priv && user)) begin
      r = cop_port_pkg::HS_ABSENT;
    end else if (f.long_op) begin
      r = cop_port_pkg::HS_WAIT;
    end
    return r;
  endfunction

  // advance only on enable and strobe low
  assign adv = i_pipe_clock_enable & ~i_pipe_advance_n;
  assign dec_next = adv ? decode_fields(i_fetched_instr_bus) : dec_q;

  // commit on LAST with condition pass
  assign commit = i_pipe_clock_enable & i_cond_pass &
    ((state_q == cop_port_pkg::EX_FIRST && ex_resp_q == cop_port_pkg::HS_LAST) ||
     (state_q == cop_port_pkg::EX_BUSY && !i_late_cancel &&
      o_execute_handshake == cop_port_pkg::HS_LAST));

  // abandon busy wait on pass low or cancel
  assign abandon = i_pipe_clock_enable & (state_q == cop_port_pkg::EX_BUSY) &
    (~i_cond_pass | i_late_cancel);

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      dec_q <= '0;
    end else if (adv) begin
      dec_q <= dec_next;
    end
  end

  // answer refreshed each enabled cycle in current mode
  // LAST for immediate ops, WAIT for long ones
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_decode_handshake <= cop_port_pkg::HS_ABSENT;
    end else if (i_pipe_clock_enable) begin
      o_decode_handshake <= respond(dec_next, ~i_user_mode_n);
    end
  end

  // execute stage tracking and execute handshake
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ex_q <= '0;
      ex_resp_q <= cop_port_pkg::HS_ABSENT;
      state_q <= cop_port_pkg::EX_IDLE;
      cnt_q <= '0;
      o_execute_handshake <= cop_port_pkg::HS_ABSENT;
    end else if (i_pipe_clock_enable) begin
      if (adv) begin
        // keep the answer present at the move
        ex_q <= dec_q;
        ex_resp_q <= o_decode_handshake;
        state_q <= (dec_q.kind != cop_port_pkg::OP_NONE) ? cop_port_pkg::EX_FIRST :
                   cop_port_pkg::EX_IDLE;
        cnt_q <= '0;
        o_execute_handshake <= cop_port_pkg::HS_ABSENT;
      end else begin
        case (state_q)
          cop_port_pkg::EX_FIRST: begin
            // WAIT then LAST on execute bus
            if (i_cond_pass && ex_resp_q == cop_port_pkg::HS_WAIT) begin
              state_q <= cop_port_pkg::EX_BUSY;
              o_execute_handshake <= (BUSY_LOAD != '0) ? cop_port_pkg::HS_WAIT :
                                     cop_port_pkg::HS_LAST;
              cnt_q <= (BUSY_LOAD != '0) ? BUSY_LOAD - 1'b1 : '0;
            end else begin
              state_q <= cop_port_pkg::EX_IDLE;
              o_execute_handshake <= cop_port_pkg::HS_ABSENT;
            end
          end
          cop_port_pkg::EX_BUSY: begin
            if (abandon || commit) begin
              state_q <= cop_port_pkg::EX_IDLE;
              o_execute_handshake <= cop_port_pkg::HS_ABSENT;
            end else begin
              o_execute_handshake <= (cnt_q != '0) ? cop_port_pkg::HS_WAIT :
                                     cop_port_pkg::HS_LAST;
              cnt_q <= (cnt_q != '0) ? cnt_q - 1'b1 : '0;
            end
          end
          default: begin
            state_q <= cop_port_pkg::EX_IDLE;
            o_execute_handshake <= cop_port_pkg::HS_ABSENT;
          end
        endcase
      end
    end
  end

  // committed work waits one cycle for late cancel
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      wb_pending_q <= 1'b0;
      wb_kind_q <= cop_port_pkg::OP_NONE;
      wb_reg_q <= '0;
      wb_sum_q <= cop_port_pkg::DATA_IDLE;
    end else if (i_pipe_clock_enable) begin
      wb_pending_q <= commit;
      if (commit) begin
        wb_kind_q <= ex_q.kind;
        wb_reg_q <= (ex_q.kind == cop_port_pkg::OP_DATA) ? ex_q.crd : ex_q.crn;
        wb_sum_q <= rdata[0] + rdata[1];
      end
    end
  end

  // word for core's memory-stage sample, zero otherwise
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_cop_to_core_data <= cop_port_pkg::DATA_IDLE;
    end else if (i_pipe_clock_enable) begin
      o_cop_to_core_data <= (commit && ex_q.kind == cop_port_pkg::OP_TO_CORE) ?
                            rdata[0] : cop_port_pkg::DATA_IDLE;
    end
  end

  // write only if not late canceled
  // take core data the cycle after commit
  assign reg_we = i_pipe_clock_enable & wb_pending_q & ~i_late_cancel &
                  (wb_kind_q != cop_port_pkg::OP_TO_CORE);
  assign reg_wdata = (wb_kind_q == cop_port_pkg::OP_TO_COP) ? i_core_to_cop_data : wb_sum_q;
  assign raddr[0] = adv ? dec_q.crn : ex_q.crn;
  assign raddr[1] = adv ? dec_q.crm : ex_q.crm;

  cop_reg_file #(
    .DW(cop_port_pkg::DATA_W),
    .AW(cop_port_pkg::REG_AW),
    .DEPTH(cop_port_pkg::REG_DEPTH),
    .NRD(2)
  ) u_regs (
    .i_mclk(i_mclk),
    .i_we(reg_we),
    .i_waddr(wb_reg_q),
    .i_wdata(reg_wdata),
    .i_raddr(raddr),
    .o_rdata(rdata)
  );

endmodule
`default_nettype wire

// File: test/cop_port_properties.sv
// cop_port_properties: port checker for the coprocessor handshake unit
// assumes one clock, edges qualified by the enable, async reset
`timescale 1ns/100ps
`default_nettype none
module cop_port_properties #(
  parameter logic [3:0] CP_NUM = 4'h5,
  parameter int BUSY_CYCLES = 2
) (
  // clock, reset and core side
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_pipe_clock_enable,
  input wire logic i_pipe_advance_n,
  input wire logic [31:0] i_fetched_instr_bus,
  input wire logic i_user_mode_n,
  input wire logic i_cond_pass,
  input wire logic i_late_cancel,
  input wire logic [31:0] i_core_to_cop_data,
  // unit answers
  input wire logic [1:0] o_decode_handshake,
  input wire logic [1:0] o_execute_handshake,
  input wire logic [31:0] o_cop_to_core_data
);
  logic en;
  logic [31:0] word_q;
  logic [31:0] w;
  logic [1:0] exp_hs;
  logic [7:0] wcnt_q;
  assign en = i_pipe_clock_enable;
  // word held in decode
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      word_q <= 32'h0000_0000;
    end else if (en && !i_pipe_advance_n) begin
      word_q <= i_fetched_instr_bus;
    end
  end
  // enabled edges spent in wait
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      wcnt_q <= 8'h00;
    end else if (o_execute_handshake != cop_port_pkg::HS_WAIT) begin
      wcnt_q <= 8'h00;
    end else if (en) begin
      wcnt_q <= wcnt_q + 8'h01;
    end
  end
  // expected decode answer
  always_comb begin
    w = i_pipe_advance_n ? word_q : i_fetched_instr_bus;
    if (w[27:24] != 4'hE || w[11:8] != CP_NUM || (w[23] && !i_user_mode_n)) begin
      exp_hs = cop_port_pkg::HS_ABSENT;
    end else if (!w[4] && w[22]) begin
      exp_hs = cop_port_pkg::HS_WAIT;
    end else begin
      exp_hs = cop_port_pkg::HS_LAST;
    end
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  sequence s_quit;
    en && o_execute_handshake != cop_port_pkg::HS_ABSENT && (i_late_cancel || !i_cond_pass
      || o_execute_handshake == cop_port_pkg::HS_LAST);
  endsequence
  AST_DECODE_ANSWER:
    assert property (en |=> o_decode_handshake == $past(exp_hs)) else $error("decode answer");
  AST_HOLD_DISABLED:
    assert property (!en |=> $stable(o_decode_handshake) && $stable(o_execute_handshake)
      && $stable(o_cop_to_core_data)) else $error("moved without enable");
  AST_WAIT_LIMIT:
    assert property (o_execute_handshake == cop_port_pkg::HS_WAIT |-> wcnt_q < BUSY_CYCLES)
    else $error("too many waits");
  AST_LAST_AFTER_WAITS:
    assert property (o_execute_handshake == cop_port_pkg::HS_LAST && wcnt_q != 8'h00
      |-> wcnt_q == BUSY_CYCLES) else $error("last too early");
  AST_ABANDON:
    assert property (s_quit |=> o_execute_handshake == cop_port_pkg::HS_ABSENT)
    else $error("execute answer not dropped");
  AST_NO_EXEC_WITHOUT_PASS:
    assert property (en && o_execute_handshake == cop_port_pkg::HS_ABSENT && !i_cond_pass
      |=> o_execute_handshake == cop_port_pkg::HS_ABSENT) else $error("busy without pass");
  AST_DATA_AFTER_COMMIT:
    assert property ($changed(o_cop_to_core_data) && o_cop_to_core_data != cop_port_pkg::DATA_IDLE
      |-> $past(i_cond_pass)) else $error("data without commit");
  AST_DATA_ONE_CYCLE:
    assert property (en && !i_cond_pass && o_cop_to_core_data != cop_port_pkg::DATA_IDLE
      |=> o_cop_to_core_data == cop_port_pkg::DATA_IDLE) else $error("data held too long");
endmodule
bind cop_handshake_unit cop_port_properties #(.CP_NUM(CP_NUM), .BUSY_CYCLES(BUSY_CYCLES)) chk (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_pipe_clock_enable(i_pipe_clock_enable),
  .i_pipe_advance_n(i_pipe_advance_n), .i_fetched_instr_bus(i_fetched_instr_bus),
  .i_user_mode_n(i_user_mode_n), .i_cond_pass(i_cond_pass), .i_late_cancel(i_late_cancel),
  .i_core_to_cop_data(i_core_to_cop_data), .o_decode_handshake(o_decode_handshake),
  .o_execute_handshake(o_execute_handshake), .o_cop_to_core_data(o_cop_to_core_data));
`default_nettype wire

// File: test/core_model.sv
// core_model: behavioural core side of the coprocessor port
// assumes one op at a time; outputs move 1 ns after the rising edge
`timescale 1ns/100ps
`default_nettype none
module core_model (
  // clock
  input wire logic i_mclk,
  // pipeline and execute control
  output logic o_clken,
  output logic o_adv_n,
  output logic [31:0] o_instr,
  output logic o_user_n,
  output logic o_pass,
  output logic o_cancel,
  output logic [31:0] o_wdata,
  // answers from the unit
  input wire logic [1:0] i_dhs,
  input wire logic [1:0] i_ehs,
  input wire logic [31:0] i_rdata
);
  logic trap;
  int waits;
  initial begin
    o_clken = 1'h1;
    o_adv_n = 1'h1;
    o_instr = 32'h0000_0000;
    o_user_n = 1'h1;
    o_pass = 1'h0;
    o_cancel = 1'h0;
    o_wdata = 32'h0000_0000;
    trap = 1'h0;
  end
  task automatic op(input logic [31:0] ins, input int stall, input logic nu, input logic pass,
    input logic cancel, input logic [31:0] wd, output logic [1:0] kept, output logic [31:0] rd);
    logic [1:0] st;
    int n;
    o_adv_n = 1'h0;
    o_instr = ins;
    @(posedge i_mclk) #1;
    o_instr = ~ins;
    o_user_n = nu;
    for (n = 0; n < stall; n++) begin
      o_clken = n != 0;
      o_adv_n = n != 0;
      @(posedge i_mclk) #1;
    end
    o_clken = 1'h1;
    o_adv_n = 1'h0;
    kept = i_dhs;
    @(posedge i_mclk) #1;
    o_adv_n = 1'h1;
    o_pass = pass;
    trap = pass && kept == cop_port_pkg::HS_ABSENT;
    st = pass ? kept : cop_port_pkg::HS_ABSENT;
    @(posedge i_mclk) #1;
    o_cancel = cancel;
    o_pass = st == cop_port_pkg::HS_WAIT && !cancel;
    n = 0;
    waits = 0;
    while (st == cop_port_pkg::HS_WAIT && n < 20) begin
      st = i_ehs;
      if (st == cop_port_pkg::HS_WAIT) begin
        waits++;
      end
      @(posedge i_mclk) #1;
      o_cancel = 1'h0;
      o_pass = i_ehs != cop_port_pkg::HS_ABSENT;
      n++;
    end
    o_wdata = (st == cop_port_pkg::HS_LAST) ? wd : ~wd;
    rd = i_rdata;
    @(posedge i_mclk) #1;
    o_cancel = 1'h0;
    o_wdata = ~wd;
  endtask
endmodule
`default_nettype wire

// File: test/tb.sv
// tb: self-checking bench for the coprocessor handshake unit
// assumes core_model drives the core side and the checker is bound
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clk;
  logic rst;
  logic en;
  logic adv_n;
  logic user_n;
  logic pass;
  logic cancel;
  logic [31:0] instr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [1:0] dhs;
  logic [1:0] ehs;
  logic [1:0] k;
  logic [31:0] r;
  int fail_count;
  int n_checks;
  core_model m (.i_mclk(clk), .o_clken(en), .o_adv_n(adv_n), .o_instr(instr), .o_user_n(user_n),
    .o_pass(pass), .o_cancel(cancel), .o_wdata(wdata), .i_dhs(dhs), .i_ehs(ehs), .i_rdata(rdata));
  cop_handshake_unit #(.CP_NUM(4'h5), .BUSY_CYCLES(2)) dut (.i_mclk(clk), .i_rst(rst),
    .i_pipe_clock_enable(en), .i_pipe_advance_n(adv_n), .i_fetched_instr_bus(instr),
    .i_user_mode_n(user_n), .i_cond_pass(pass), .i_late_cancel(cancel),
    .i_core_to_cop_data(wdata), .o_decode_handshake(dhs), .o_execute_handshake(ehs),
    .o_cop_to_core_data(rdata));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // flags: transfer, to core, privileged, long
  function automatic logic [31:0] ins(input logic [3:0] f, input logic [3:0] n,
    input logic [3:0] d, input logic [3:0] s);
    return {8'hEE, f[1], f[0], 1'h0, f[2], n, d, 4'h5, 3'h0, f[3], s};
  endfunction
  task automatic put(input logic [3:0] n, input logic [31:0] v, input logic c, input int s);
    m.op(ins(4'h8, n, 4'h0, 4'h0), s, 1'h1, 1'h1, c, v, k, r);
    check(32'(k), 32'(cop_port_pkg::HS_LAST));
  endtask
  task automatic get(input logic [3:0] n, input logic [31:0] v);
    m.op(ins(4'hC, n, 4'h0, 4'h0), 0, 1'h1, 1'h1, 1'h0, 32'h0000_0000, k, r);
    check(r, v);
  endtask
  task automatic data_op(input logic [3:0] f, input logic [3:0] d, input logic c,
    input logic [1:0] e);
    m.op(ins(f, 4'h1, d, 4'h2), 0, 1'h1, 1'h1, c, 32'h0000_0000, k, r);
    check(32'(k), 32'(e));
  endtask
  task automatic t_reset();
    rst = 1'h1;
    repeat (2) @(posedge clk);
    #1 rst = 1'h0;
    check(32'(dhs), 32'(cop_port_pkg::HS_ABSENT));
    check(32'(ehs), 32'(cop_port_pkg::HS_ABSENT));
    check(rdata, cop_port_pkg::DATA_IDLE);
    @(posedge clk) #1;
    check(32'(dhs), 32'(cop_port_pkg::HS_ABSENT));
    check(32'(ehs), 32'(cop_port_pkg::HS_ABSENT));
    get(4'h2, 32'h600D_0002);
  endtask
  task automatic t_xfer();
    put(4'h3, 32'hA5A5_0F01, 1'h0, 0);
    get(4'h3, 32'hA5A5_0F01);
    put(4'h3, 32'h1234_5678, 1'h0, 3);
    get(4'h3, 32'h1234_5678);
  endtask
  task automatic t_data_op();
    put(4'h1, 32'h0000_0005, 1'h0, 0);
    put(4'h2, 32'h0000_0007, 1'h0, 0);
    data_op(4'h0, 4'h4, 1'h0, cop_port_pkg::HS_LAST);
    get(4'h4, 32'h0000_000C);
    data_op(4'h1, 4'h6, 1'h0, cop_port_pkg::HS_WAIT);
    check(32'(m.waits), 32'h0000_0002);
    get(4'h6, 32'h0000_000C);
  endtask
  task automatic t_cancel();
    put(4'h1, 32'hDEAD_0000, 1'h1, 0);
    get(4'h1, 32'h0000_0005);
    put(4'h7, 32'h0000_0077, 1'h0, 0);
    data_op(4'h1, 4'h7, 1'h1, cop_port_pkg::HS_WAIT);
    check(32'(m.waits), 32'h0000_0001);
    get(4'h7, 32'h0000_0077);
    data_op(4'h0, 4'h7, 1'h1, cop_port_pkg::HS_LAST);
    get(4'h7, 32'h0000_0077);
    m.op(ins(4'h8, 4'h2, 4'h0, 4'h0), 0, 1'h1, 1'h0, 1'h0, 32'h0BAD_0001, k, r);
    get(4'h2, 32'h0000_0007);
  endtask
  task automatic t_priv();
    m.op(ins(4'hC, 4'h2, 4'h0, 4'h0), 0, 1'h0, 1'h1, 1'h0, 32'h0000_0000, k, r);
    check(r, 32'h0000_0007);
    m.op(ins(4'hA, 4'h2, 4'h0, 4'h0), 0, 1'h0, 1'h1, 1'h0, 32'h0BAD_0002, k, r);
    check(32'(k), 32'(cop_port_pkg::HS_ABSENT));
    check(32'(m.trap), 32'h0000_0001);
    m.op(ins(4'h8, 4'h2, 4'h0, 4'h0) ^ 32'h0000_0300, 0, 1'h1, 1'h1, 1'h0, 32'h0BAD_0003, k, r);
    check(32'(k), 32'(cop_port_pkg::HS_ABSENT));
    m.op(ins(4'hA, 4'h2, 4'h0, 4'h0), 2, 1'h1, 1'h1, 1'h0, 32'h600D_0002, k, r);
    check(32'(k), 32'(cop_port_pkg::HS_LAST));
    get(4'h2, 32'h600D_0002);
  endtask
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    summarize();
  end
  initial begin
    fail_count = 0;
    n_checks = 0;
    rst = 1'h1;
    repeat (20) @(posedge clk);
    #1 rst = 1'h0;
    @(posedge clk) #1;
    t_xfer();
    t_data_op();
    t_cancel();
    t_priv();
    t_reset();
    summarize();
  end
endmodule
`default_nettype wire
